// ==== common/fro_defs.svh ====
`ifndef FRO_DEFS_SVH
`define FRO_DEFS_SVH

// Command codes of the two response bytes.
`define FRO_OC_CODE 8'h47
`define FRO_OT_CODE 8'hD6

// Reset values of the two response bytes.
`define FRO_OC_RESET 8'h00
`define FRO_OT_RESET 8'hC0

// Field layout shared by both response bytes.
`define FRO_RESP_MSB 7
`define FRO_RESP_LSB 6
`define FRO_RETRY_MSB 5
`define FRO_RETRY_LSB 3
`define FRO_DELAY_MSB 2
`define FRO_DELAY_LSB 0

// Response codes and the no-restart retry code.
`define FRO_RESP_00 2'h0
`define FRO_RESP_01 2'h1
`define FRO_RESP_10 2'h2
`define FRO_RESP_11 2'h3
`define FRO_RETRY_NONE 3'h0
`define FRO_DELAY_ZERO 3'h0

// Status bit positions.
`define FRO_SB_NOTA 0
`define FRO_SB_CML 1
`define FRO_SB_IOUT_OC 4
`define FRO_SW_MFR 12
`define FRO_SW_IOUT 14
`define FRO_SI_OC_FAULT 7
`define FRO_SM_OT_FAULT 6

// Delay unit of the overcurrent delay field, and the clock rate.
`define FRO_DELAY_UNIT_MS 16
`define FRO_CLK_KHZ 10000
`define FRO_DELAY_UNIT_CYCLES (`FRO_DELAY_UNIT_MS * `FRO_CLK_KHZ)

`endif

// ==== common/fro_pkg.sv ====
package fro_pkg;

  // Output control states, Gray coded along run, limit, retry, latch.
  typedef enum logic [2:0] {
    FRO_RUN = 3'h0,
    FRO_LIMIT = 3'h1,
    FRO_RETRY = 3'h3,
    FRO_LATCH = 3'h2,
    FRO_OT_WAIT = 3'h6
  } fro_state_t;

endpackage

// ==== hw/fro_delay_timer.sv ====
`timescale 1ns/1ps
`include "fro_defs.svh"

// Counts a number of delay units and pulses done once at the end.
module fro_delay_timer #(
  parameter int unsigned UNIT_CYCLES = `FRO_DELAY_UNIT_CYCLES,
  parameter int unsigned UNIT_W = 3,
  parameter int unsigned PRE_W = $clog2(UNIT_CYCLES)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [UNIT_W-1:0] units,
  output logic done
);

  logic [PRE_W-1:0] pre;
  logic [UNIT_W-1:0] left;
  logic busy;
  wire unit_end = (pre == PRE_W'(UNIT_CYCLES - 1));

  // A start always reloads, so a stale count can never fire late.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre <= '0;
      left <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      pre <= '0;
      left <= units;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy && left == '0) begin
      busy <= 1'b0;
      done <= 1'b1;
    end else if (busy) begin
      done <= 1'b0;
      pre <= unit_end ? '0 : pre + 1'b1;
      if (unit_end) begin
        left <= left - 1'b1;
      end
    end else begin
      done <= 1'b0;
    end
  end

endmodule

// ==== hw/fro_top.sv ====
`timescale 1ns/1ps
`include "fro_defs.svh"

module fro_top #(
  parameter int unsigned DELAY_UNIT_CYCLES = `FRO_DELAY_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ack,
  output logic cmd_nack,
  output logic [7:0] cmd_rdata,
  input wire logic clear_faults,
  input wire logic run_pin,
  input wire logic operation_on,
  input wire logic oc_fault,
  input wire logic oc_in_limit,
  input wire logic ot_fault,
  input wire logic retry_done,
  output logic retry_start,
  output logic output_enable,
  output logic current_limit_en,
  input wire logic alert_i,
  output logic alert_o,
  output logic alert_oe_n,
  output logic alert_seen,
  output logic [7:0] status_byte,
  output logic [15:0] status_word,
  output logic [7:0] status_iout,
  output logic [7:0] vendor_status,
  output fro_pkg::fro_state_t resp_state
);
  import fro_pkg::*;

  // Every check below runs on the system clock and rests while reset is held.
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [7:0] overcurrent_response_cfg;
  logic [7:0] die_overtemp_response_cfg;
  logic oc_flag;
  logic ot_flag;
  logic cml_flag;
  logic next_oc_flag;
  logic next_ot_flag;
  logic next_cml_flag;
  logic run_q;
  logic delay_done;
  logic delay_start;
  fro_state_t next_state;

  // Command and field decode.
  wire run_cmd = run_pin & operation_on;
  wire run_rise = run_cmd & ~run_q;
  wire flag_clear = clear_faults | run_rise;
  wire wr_oc = cmd_valid & cmd_write & (cmd_code == `FRO_OC_CODE);
  wire wr_ot = cmd_valid & cmd_write & (cmd_code == `FRO_OT_CODE);
  wire known = (cmd_code == `FRO_OC_CODE) | (cmd_code == `FRO_OT_CODE);
  wire [1:0] oc_resp = overcurrent_response_cfg[`FRO_RESP_MSB:`FRO_RESP_LSB];
  wire [2:0] oc_retry = overcurrent_response_cfg[`FRO_RETRY_MSB:`FRO_RETRY_LSB];
  wire [2:0] oc_delay = overcurrent_response_cfg[`FRO_DELAY_MSB:`FRO_DELAY_LSB];
  wire [1:0] ot_resp = die_overtemp_response_cfg[`FRO_RESP_MSB:`FRO_RESP_LSB];
  wire [1:0] w_resp = cmd_wdata[`FRO_RESP_MSB:`FRO_RESP_LSB];
  wire [2:0] w_retry = cmd_wdata[`FRO_RETRY_MSB:`FRO_RETRY_LSB];

  // Write legality; an illegal byte is not stored and raises a CML fault.
  wire oc_bad = (w_resp == `FRO_RESP_01);
  wire ot_bad = (w_resp == `FRO_RESP_00) | (w_resp == `FRO_RESP_01)
    | (w_retry != `FRO_RETRY_NONE);
  wire cml_event = (wr_oc & oc_bad) | (wr_ot & ot_bad);

  // Response byte storage; each access moves exactly one byte.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overcurrent_response_cfg <= `FRO_OC_RESET;
      die_overtemp_response_cfg <= `FRO_OT_RESET;
    end else begin
      if (wr_oc && !oc_bad) begin
        overcurrent_response_cfg <= cmd_wdata;
      end
      if (wr_ot && !ot_bad) begin
        // The delay bits mean nothing here, so they are stored as zero.
        die_overtemp_response_cfg <= {cmd_wdata[`FRO_RESP_MSB:`FRO_RETRY_LSB], `FRO_DELAY_ZERO};
      end
    end
  end

  // Answers come one cycle after the request so read data is registered.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_ack <= 1'b0;
      cmd_nack <= 1'b0;
      cmd_rdata <= 8'h00;
    end else begin
      cmd_ack <= cmd_valid & known;
      cmd_nack <= cmd_valid & ~known;
      if (cmd_valid && !cmd_write && known) begin
        cmd_rdata <= (cmd_code == `FRO_OC_CODE) ? overcurrent_response_cfg
                                                : die_overtemp_response_cfg;
      end
    end
  end

  // Sticky fault flags; a fault present in the clearing cycle keeps its flag.
  always_comb begin
    next_oc_flag = oc_fault | (oc_flag & ~flag_clear);
    next_ot_flag = ot_fault | (ot_flag & ~flag_clear);
    next_cml_flag = cml_event | (cml_flag & ~flag_clear);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oc_flag <= 1'b0;
      ot_flag <= 1'b0;
      cml_flag <= 1'b0;
      run_q <= 1'b0;
    end else begin
      oc_flag <= next_oc_flag;
      ot_flag <= next_ot_flag;
      cml_flag <= next_cml_flag;
      run_q <= run_cmd;
    end
  end

  // Status images are registered from the next flag values, so they move with the flags.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_byte <= 8'h00;
      status_word <= 16'h0000;
      status_iout <= 8'h00;
      vendor_status <= 8'h00;
    end else begin
      status_byte <= 8'h00;
      status_byte[`FRO_SB_NOTA] <= next_oc_flag | next_ot_flag;
      status_byte[`FRO_SB_IOUT_OC] <= next_oc_flag;
      status_byte[`FRO_SB_CML] <= next_cml_flag;
      status_word <= 16'h0000;
      status_word[`FRO_SB_NOTA] <= next_oc_flag | next_ot_flag;
      status_word[`FRO_SB_IOUT_OC] <= next_oc_flag;
      status_word[`FRO_SB_CML] <= next_cml_flag;
      status_word[`FRO_SW_IOUT] <= next_oc_flag;
      status_word[`FRO_SW_MFR] <= next_ot_flag;
      status_iout <= 8'h00;
      status_iout[`FRO_SI_OC_FAULT] <= next_oc_flag;
      vendor_status <= 8'h00;
      vendor_status[`FRO_SM_OT_FAULT] <= next_ot_flag;
    end
  end

  // Alert is open drain: the pin is only ever pulled low, never driven high.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alert_oe_n <= 1'b1;
      alert_seen <= 1'b0;
    end else begin
      alert_oe_n <= ~(next_oc_flag | next_ot_flag | next_cml_flag);
      alert_seen <= ~alert_i;
    end
  end

  assign alert_o = 1'b0;

  // Output control. Overtemperature is checked first because it always
  // removes the output, whatever the overcurrent response says.
  always_comb begin
    next_state = resp_state;
    delay_start = 1'b0;
    if (!run_cmd) begin
      // Commanded off: stop any retry and wait for the next turn-on.
      next_state = FRO_RUN;
    end else begin
      unique case (resp_state)
        FRO_RUN, FRO_LIMIT, FRO_RETRY: begin
          if (ot_fault && ot_resp == `FRO_RESP_10) begin
            next_state = FRO_LATCH;
          end else if (ot_fault) begin
            next_state = FRO_OT_WAIT;
          end else if (resp_state == FRO_RETRY) begin
            if (retry_done) begin
              next_state = FRO_RUN;
            end
          end else if (resp_state == FRO_LIMIT) begin
            if (!oc_in_limit) begin
              next_state = FRO_RUN;
            end else if (delay_done) begin
              next_state = (oc_retry == `FRO_RETRY_NONE) ? FRO_LATCH : FRO_RETRY;
            end
          end else if (oc_fault) begin
            if (oc_resp == `FRO_RESP_10) begin
              next_state = FRO_LIMIT;
              delay_start = 1'b1;
            end else if (oc_resp == `FRO_RESP_11) begin
              next_state = (oc_retry == `FRO_RETRY_NONE) ? FRO_LATCH : FRO_RETRY;
            end
          end
        end
        FRO_LATCH: begin
          next_state = FRO_LATCH;
        end
        FRO_OT_WAIT: begin
          if (!ot_fault) begin
            next_state = FRO_RUN;
          end
        end
        default: begin
          next_state = FRO_LATCH;
        end
      endcase
    end
  end

  // State and drive outputs are registered together so they never disagree.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resp_state <= FRO_RUN;
      output_enable <= 1'b0;
      current_limit_en <= 1'b0;
      retry_start <= 1'b0;
    end else begin
      resp_state <= next_state;
      output_enable <= run_cmd & (next_state == FRO_RUN || next_state == FRO_LIMIT);
      // Clamping stays armed in running states unless the output is to trip at once.
      current_limit_en <= run_cmd & (next_state == FRO_LIMIT
        || (next_state == FRO_RUN && oc_resp != `FRO_RESP_11));
      retry_start <= (next_state == FRO_RETRY) && (resp_state != FRO_RETRY);
    end
  end

  // The limit delay: a long count, kept in its own timer.
  fro_delay_timer #(
    .UNIT_CYCLES(DELAY_UNIT_CYCLES),
    .UNIT_W(3)
  ) u_delay (
    .clk(clk),
    .rstn(rstn),
    .start(delay_start),
    .units(oc_delay),
    .done(delay_done)
  );

  sequence oc_trip_s;
    resp_state == FRO_RUN && run_cmd && oc_fault && !ot_fault;
  endsequence

  sequence retry_end_s;
    resp_state == FRO_RETRY && run_cmd && retry_done && !ot_fault;
  endsequence

  oc_sets_status_a: assert property (
    oc_fault |=> status_iout[`FRO_SI_OC_FAULT] && status_byte[`FRO_SB_IOUT_OC]
      && status_byte[`FRO_SB_NOTA] && status_word[`FRO_SW_IOUT])
    else $error("Overcurrent did not set its status bits.");

  alert_on_fault_a: assert property (
    (oc_fault || ot_fault) |=> !alert_oe_n)
    else $error("Alert not pulled after a fault.");

  ignore_keeps_run_a: assert property (
    oc_trip_s and (oc_resp == `FRO_RESP_00) |=> resp_state == FRO_RUN && current_limit_en)
    else $error("Ignore response left the running state.");

  limit_expiry_a: assert property (
    resp_state == FRO_LIMIT && run_cmd && oc_in_limit && delay_done && !ot_fault
      |=> !output_enable && resp_state inside {FRO_LATCH, FRO_RETRY})
    else $error("Limit delay expiry did not shut down.");

  shutdown_now_a: assert property (
    oc_trip_s and (oc_resp == `FRO_RESP_11) |=> !output_enable)
    else $error("Immediate shutdown did not drop the output.");

  latch_holds_a: assert property (
    resp_state == FRO_LATCH && run_cmd |=> resp_state == FRO_LATCH && !output_enable)
    else $error("Latched-off output came back without an enable cycle.");

  retry_restart_a: assert property (
    retry_end_s |=> output_enable ##0 resp_state == FRO_RUN)
    else $error("Retry interval end did not restart the output.");

  flag_sticky_a: assert property (
    $fell(oc_flag) |-> $past(flag_clear))
    else $error("Overcurrent flag cleared without a clearing event.");

  ot_sets_status_a: assert property (
    ot_fault |=> vendor_status[`FRO_SM_OT_FAULT] && status_word[`FRO_SW_MFR])
    else $error("Overtemperature did not set its status bits.");

  ot_bad_write_a: assert property (
    wr_ot && (w_resp == `FRO_RESP_00 || w_resp == `FRO_RESP_01)
      |=> status_byte[`FRO_SB_CML] && $stable(die_overtemp_response_cfg))
    else $error("Unsupported overtemperature response was accepted.");

  ot_hold_a: assert property (
    resp_state == FRO_OT_WAIT && run_cmd && ot_fault |=> !output_enable ##1 1'b1)
    else $error("Output enabled while overtemperature persists.");

  ot_retry_bad_a: assert property (
    wr_ot && w_retry != `FRO_RETRY_NONE |=> status_byte[`FRO_SB_CML])
    else $error("Illegal overtemperature retry raised no CML fault.");

  oc_bad_write_a: assert property (
    wr_oc && w_resp == `FRO_RESP_01 |=> status_byte[`FRO_SB_CML] && $stable(overcurrent_response_cfg))
    else $error("Unsupported overcurrent response was accepted.");

  oc_store_a: assert property (
    wr_oc && !oc_bad |=> overcurrent_response_cfg == $past(cmd_wdata))
    else $error("Legal overcurrent byte was not stored whole.");

  read_back_a: assert property (
    cmd_valid && !cmd_write && cmd_code == `FRO_OC_CODE
      |=> cmd_ack && cmd_rdata == $past(overcurrent_response_cfg))
    else $error("Read of the overcurrent byte returned the wrong value.");

  nack_unknown_a: assert property (
    cmd_valid && !known |=> cmd_nack && !cmd_ack)
    else $error("Unknown command code was not refused.");

  ot_latch_a: assert property (
    run_cmd && ot_fault && ot_resp == `FRO_RESP_10 && resp_state inside {FRO_RUN, FRO_LIMIT, FRO_RETRY}
      |=> resp_state == FRO_LATCH && !output_enable)
    else $error("Overtemperature shutdown response did not latch the output off.");

  ot_wait_exit_a: assert property (
    resp_state == FRO_OT_WAIT && run_cmd && !ot_fault |=> resp_state == FRO_RUN && output_enable)
    else $error("Output did not return after overtemperature cleared.");

endmodule

// ==== testbench/fro_host_model.sv ====
`timescale 1ns/1ps

// Far side of the block: the shared alert wire with its pull-up, and the retry-interval timer.
module fro_host_model #(
  parameter int RETRY_CYCLES = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic alert_o,
  input wire logic alert_oe_n,
  input wire logic retry_start,
  output logic alert_i,
  output logic retry_done
);
  int count;

  // The pull-up lifts the wire whenever nobody pulls it, so a released line never shows a stale low.
  assign alert_i = alert_oe_n ? 1'b1 : alert_o;

  // A started interval runs down and answers with a single pulse; a new start restarts it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 0;
      retry_done <= 1'b0;
    end else begin
      retry_done <= (count == 1);
      if (retry_start) begin
        count <= RETRY_CYCLES;
      end else if (count > 0) begin
        count <= count - 1;
      end
    end
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "fro_defs.svh"

`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
  end \
end

module tb;
  import fro_pkg::*;
  localparam int UNIT = 4;
  localparam int RETRY = 12;
  logic clk, rstn, cmd_valid, cmd_write, clear_faults, run_pin, operation_on, oc_fault, oc_in_limit, ot_fault;
  logic retry_done, retry_start, alert_i, alert_o, alert_oe_n, alert_seen;
  logic cmd_ack, cmd_nack, output_enable, current_limit_en;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, status_byte, status_iout, vendor_status, oc_cfg, ot_cfg, v;
  logic [15:0] status_word;
  logic [7:0] q[$];
  fro_state_t resp_state;
  int bad_count, comparisons, cycles, m_oc, m_ot, m_cml, k;

  fro_top #(.DELAY_UNIT_CYCLES(UNIT)) u_fro_top (
    .clk, .rstn, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .cmd_ack, .cmd_nack, .cmd_rdata,
    .clear_faults, .run_pin, .operation_on, .oc_fault, .oc_in_limit, .ot_fault, .retry_done,
    .retry_start, .output_enable, .current_limit_en, .alert_i, .alert_o, .alert_oe_n, .alert_seen,
    .status_byte, .status_word, .status_iout, .vendor_status, .resp_state
  );

  fro_host_model #(.RETRY_CYCLES(RETRY)) u_fro_host_model (
    .clk, .rstn, .alert_o, .alert_oe_n, .retry_start, .alert_i, .retry_done
  );

  // Free-running system clock at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // A hung wait must not stall the run; the ceiling is far above the few hundred cycles used.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One request per call; the answer stands only in the cycle after the taking edge, so look there.
  task automatic cmd(input logic w, input logic [7:0] code, input logic [7:0] d, input logic ack);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = code;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    `CHK("cmd_ack", ack, cmd_ack)
    `CHK("cmd_nack", !ack, cmd_nack)
  endtask

  task automatic rd(input logic [7:0] code, input logic [7:0] ex);
    cmd(1'b0, code, 8'h00, 1'b1);
    `CHK("cmd_rdata", ex, cmd_rdata)
  endtask

  // Model of the write path: unsupported values are acked but not stored and raise the CML flag.
  task automatic wr(input logic [7:0] code, input logic [7:0] d);
    logic bad;
    if (code == `FRO_OC_CODE) bad = (d[7:6] == `FRO_RESP_01);
    else bad = (d[7:6] < `FRO_RESP_10) || (d[5:3] != `FRO_RETRY_NONE);
    cmd(1'b1, code, d, 1'b1);
    if (bad) m_cml = 1;
    else if (code == `FRO_OC_CODE) oc_cfg = d;
    else ot_cfg = {d[7:3], `FRO_DELAY_ZERO};
  endtask

  // Status registers and the alert pull are worked out from the model's fault flags.
  task automatic chk_status();
    logic [7:0] b;
    @(negedge clk);
    b = 8'h00;
    b[`FRO_SB_NOTA] = 1'(m_oc | m_ot);
    b[`FRO_SB_CML] = 1'(m_cml);
    b[`FRO_SB_IOUT_OC] = 1'(m_oc);
    `CHK("status_byte", b, status_byte)
    `CHK("status_word", {1'b0, m_oc[0], 1'b0, m_ot[0], 4'h0, b}, status_word)
    `CHK("status_iout", {m_oc[0], 7'h00}, status_iout)
    `CHK("vendor_status", {1'b0, m_ot[0], 6'h00}, vendor_status)
    `CHK("alert_oe_n", !(m_oc | m_ot | m_cml), alert_oe_n)
    `CHK("alert_seen", 1'(m_oc | m_ot | m_cml), alert_seen)
    `CHK("alert_o", 1'b0, alert_o)
  endtask

  task automatic clr();
    @(negedge clk);
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
    m_oc = 0;
    m_ot = 0;
    m_cml = 0;
  endtask

  // Turning the output off and on again clears the flags and brings the output back.
  // The pin or the operation command is dropped at random; the seen alert lags the pull by one cycle.
  task automatic run_cycle();
    @(negedge clk);
    if ($urandom_range(1) == 1) operation_on = 1'b0;
    else run_pin = 1'b0;
    @(negedge clk);
    `CHK("output_enable", 1'b0, output_enable)
    run_pin = 1'b1;
    operation_on = 1'b1;
    m_oc = 0;
    m_ot = 0;
    m_cml = 0;
    @(negedge clk);
    chk_status();
    @(negedge clk);
    `CHK("output_enable", 1'b1, output_enable)
  endtask

  task automatic oc_pulse();
    @(negedge clk);
    oc_fault = 1'b1;
    @(negedge clk);
    oc_fault = 1'b0;
    m_oc = 1;
  endtask

  initial begin
    {rstn, cmd_valid, cmd_write, clear_faults, oc_fault, oc_in_limit, ot_fault} = 7'h00;
    {cmd_code, cmd_wdata} = 16'h0000;
    run_pin = 1'b1;
    operation_on = 1'b1;
    {m_oc, m_ot, m_cml} = 0;
    oc_cfg = `FRO_OC_RESET;
    ot_cfg = `FRO_OT_RESET;
    v = 8'($urandom(56));
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    rd(`FRO_OC_CODE, oc_cfg);
    rd(`FRO_OT_CODE, ot_cfg);
    cmd(1'b0, 8'h55, 8'h00, 1'b0);
    chk_status();
    // Response 00: flags and alert, output keeps running with the clamp on.
    oc_pulse();
    chk_status();
    `CHK("output_enable", 1'b1, output_enable)
    `CHK("current_limit_en", 1'b1, current_limit_en)
    repeat (5) @(negedge clk);
    chk_status();
    clr();
    chk_status();
    // Random legal bytes read back whole; response 01 is refused.
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom());
      if (v[7:6] == `FRO_RESP_01) v[7] = 1'b1;
      wr(`FRO_OC_CODE, v);
      rd(`FRO_OC_CODE, oc_cfg);
    end
    wr(`FRO_OC_CODE, 8'h7F);
    rd(`FRO_OC_CODE, oc_cfg);
    chk_status();
    clr();
    // Unsupported responses and retry values of the overtemperature byte.
    q = {8'h00, 8'h47, 8'h48, 8'hC8, 8'hB8};
    foreach (q[i]) begin
      wr(`FRO_OT_CODE, q[i]);
      rd(`FRO_OT_CODE, ot_cfg);
      chk_status();
      clr();
    end
    // Immediate shutdown without restart; the delay field must not matter here.
    wr(`FRO_OC_CODE, 8'hC0 | 8'($urandom_range(7)));
    oc_pulse();
    `CHK("output_enable", 1'b0, output_enable)
    repeat (30) @(negedge clk);
    `CHK("output_enable", 1'b0, output_enable)
    `CHK("resp_state", FRO_LATCH, resp_state)
    chk_status();
    run_cycle();
    `CHK("current_limit_en", 1'b0, current_limit_en)
    // Immediate shutdown with restart after the external interval.
    wr(`FRO_OC_CODE, 8'hF8);
    oc_pulse();
    `CHK("output_enable", 1'b0, output_enable)
    k = 0;
    while (output_enable !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    `CHK("retry_wait", 1'b1, 1'(k >= RETRY - 2 && k <= RETRY + 8))
    clr();
    // Limit for two delay units, still limiting at the end, then latch off.
    wr(`FRO_OC_CODE, 8'h82);
    oc_in_limit = 1'b1;
    oc_pulse();
    `CHK("current_limit_en", 1'b1, current_limit_en)
    k = 1;
    while (output_enable === 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    `CHK("limit_time", 1'b1, 1'(k >= 2 * UNIT && k <= 2 * UNIT + 6))
    `CHK("resp_state", FRO_LATCH, resp_state)
    oc_in_limit = 1'b0;
    run_cycle();
    oc_pulse();
    repeat (20) @(negedge clk);
    `CHK("output_enable", 1'b1, output_enable)
    clr();
    // Reset response of the overtemperature byte: off only while the fault lasts.
    @(negedge clk);
    ot_fault = 1'b1;
    m_ot = 1;
    repeat (4) @(negedge clk);
    `CHK("output_enable", 1'b0, output_enable)
    ot_fault = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("output_enable", 1'b1, output_enable)
    chk_status();
    clr();
    wr(`FRO_OT_CODE, 8'h80 | 8'($urandom_range(7)));
    rd(`FRO_OT_CODE, ot_cfg);
    @(negedge clk);
    ot_fault = 1'b1;
    m_ot = 1;
    @(negedge clk);
    ot_fault = 1'b0;
    repeat (10) @(negedge clk);
    `CHK("output_enable", 1'b0, output_enable)
    run_cycle();
    // A reset in mid-run brings both response bytes back to their reset values.
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    rd(`FRO_OC_CODE, `FRO_OC_RESET);
    rd(`FRO_OT_CODE, `FRO_OT_RESET);
    end_of_test();
  end
endmodule
